// ### rtl/mssc_map.svh
// Register offsets, field positions, reset values and timing counts of the strap and sideband block
`ifndef MSSC_MAP_SVH
`define MSSC_MAP_SVH

`define MSSC_ADDR_W 8
`define MSSC_OFS_GPIO_OE 8'h04
`define MSSC_OFS_GPIO_OUT 8'h08
`define MSSC_OFS_GPIO_IN 8'h0C
`define MSSC_OFS_NVM_CTRL 8'h10
`define MSSC_OFS_STRAP 8'h14
`define MSSC_OFS_CLKREQ 8'h18

`define MSSC_RST_GPIO_OE 8'h00
`define MSSC_RST_GPIO_OUT 8'h00
`define MSSC_RST_NVM_CTRL 3'h0

`define MSSC_NVM_CLK_BIT 0
`define MSSC_NVM_DOUT_BIT 1
`define MSSC_NVM_DOE_BIT 2
`define MSSC_NVM_DIN_BIT 3

`define MSSC_STRAP_NVM_EN_BIT 0
`define MSSC_STRAP_SMBUS_BIT 1
`define MSSC_STRAP_STATUS_BIT 2
`define MSSC_STRAP_PWR_BIT 3
`define MSSC_STRAP_DBG_EN_BIT 4
`define MSSC_STRAP_ADDR_LSB 8
`define MSSC_STRAP_DBG_SEL_LSB 16
`define MSSC_STRAP_DONE_BIT 31

`define MSSC_MGMT_ADDR_MSB 7
`define MSSC_MGMT_ADDR_LSB 5
`define MSSC_DBG_SEL_MSB 4

`define MSSC_SETTLE_CYCLES 2'h3

`endif

// ### rtl/mssc_pkg.sv
// Types shared by the strap and sideband block
package mssc_pkg;

  typedef enum logic [0:0] {
    MSSC_ST_SETTLE,
    MSSC_ST_RUN
  } mssc_state_type;

  typedef enum logic [0:0] {
    MSSC_PROTO_I2C,
    MSSC_PROTO_SMBUS
  } mssc_proto_type;

endpackage

// ### rtl/mssc_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module mssc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clock_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  genvar g_bit;
  generate
    for (g_bit = 0; g_bit < WIDTH; g_bit = g_bit + 1) begin : g_stage
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else if (i_clock_en) begin
          meta_reg <= i_async[g_bit];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g_bit] = sync_reg;
    end
  endgenerate

endmodule

// ### rtl/mssc_top.sv
// Strap capture, sideband pins and register port of the packet switch
`timescale 1ns/1ps
`include "mssc_map.svh"
module mssc_top
  import mssc_pkg::*;
#(
  parameter int GPIO_W = 8,
  parameter int PORTS = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clock_en,
  input wire logic [`MSSC_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_nvm_serial_clock,
  input wire logic i_nvm_serial_data,
  output logic o_nvm_serial_data,
  output logic o_nvm_serial_data_oe,
  input wire logic i_mgmt_bus_clock,
  input wire logic i_mgmt_bus_data,
  output logic o_mgmt_bus_data,
  output logic o_mgmt_bus_data_oe,
  input wire logic i_mgmt_data_drive_low,
  input wire logic i_mgmt_protocol_select,
  output logic o_mgmt_clock_in,
  output logic o_mgmt_data_in,
  output logic [2:0] o_mgmt_address,
  output logic o_mgmt_smbus_mode,
  input wire logic i_manufacturing_test,
  input wire logic i_scan_enable,
  output logic o_scan_enable,
  output logic o_scan_enable_oe,
  output logic o_scan_enable_in,
  input wire logic [GPIO_W-1:0] i_gpio,
  output logic [GPIO_W-1:0] o_gpio,
  output logic [GPIO_W-1:0] o_gpio_oe,
  input wire logic i_debug_enable_strap,
  output logic o_debug_mode,
  output logic [4:0] o_debug_select,
  input wire logic i_power_saving_select,
  output logic o_power_saving_enable,
  input wire logic i_status_or_substate_select,
  input wire logic [PORTS-1:0] i_port_status,
  output logic [PORTS-1:0] o_port_status_out,
  input wire logic [PORTS-1:0] i_clock_request_n,
  output logic [PORTS-1:0] o_refclk_pll_enable,
  output logic o_strap_done
);

  localparam int SYNC_W = GPIO_W + PORTS + 9;

  logic [SYNC_W-1:0] pin_async;
  logic [SYNC_W-1:0] pin_sync;
  logic [GPIO_W-1:0] gpio_sync;
  logic [PORTS-1:0] clkreq_n_sync;
  logic nvm_data_sync;
  logic mgmt_clock_sync;
  logic mgmt_data_sync;
  logic power_sync;
  logic select_sync;
  logic smbus_sync;
  logic debug_sync;
  logic scan_sync;
  logic test_sync;

  mssc_state_type state_reg;
  logic [1:0] settle_reg;
  logic nvm_enable_reg;
  mssc_proto_type proto_reg;
  logic status_mode_reg;
  logic power_strap_reg;
  logic debug_strap_reg;
  logic [2:0] addr_strap_reg;

  logic [GPIO_W-1:0] gpio_oe_reg;
  logic [GPIO_W-1:0] gpio_out_reg;
  logic [2:0] nvm_ctrl_reg;
  logic [31:0] rdata_next;
  logic [31:0] strap_word;

  assign pin_async = {i_gpio, i_clock_request_n, i_nvm_serial_data, i_mgmt_bus_clock, i_mgmt_bus_data,
                      i_power_saving_select, i_status_or_substate_select, i_debug_enable_strap,
                      i_scan_enable, i_manufacturing_test, i_mgmt_protocol_select};

  mssc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_clock_en(i_clock_en),
    .i_async(pin_async),
    .o_sync(pin_sync)
  );

  assign gpio_sync = pin_sync[SYNC_W-1 -: GPIO_W];
  assign clkreq_n_sync = pin_sync[PORTS+8:9];
  assign nvm_data_sync = pin_sync[8];
  assign mgmt_clock_sync = pin_sync[7];
  assign mgmt_data_sync = pin_sync[6];
  assign power_sync = pin_sync[5];
  assign select_sync = pin_sync[4];
  assign debug_sync = pin_sync[3];
  assign scan_sync = pin_sync[2];
  assign test_sync = pin_sync[1];

  // Strap capture once the synchronisers have filled after reset
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= MSSC_ST_SETTLE;
      settle_reg <= 2'h0;
    end else if (i_clock_en) begin
      case (state_reg)
        MSSC_ST_SETTLE: begin
          if (settle_reg == `MSSC_SETTLE_CYCLES) begin
            state_reg <= MSSC_ST_RUN;
          end else begin
            settle_reg <= settle_reg + 2'h1;
          end
        end
        MSSC_ST_RUN: begin
          state_reg <= MSSC_ST_RUN;
        end
        default: begin
          state_reg <= MSSC_ST_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nvm_enable_reg <= 1'b0;
      proto_reg <= MSSC_PROTO_I2C;
      status_mode_reg <= 1'b0;
      power_strap_reg <= 1'b0;
      debug_strap_reg <= 1'b1;
      addr_strap_reg <= 3'h0;
    end else if (i_clock_en && state_reg == MSSC_ST_SETTLE && settle_reg == `MSSC_SETTLE_CYCLES) begin
      nvm_enable_reg <= nvm_data_sync;
      proto_reg <= smbus_sync ? MSSC_PROTO_SMBUS : MSSC_PROTO_I2C;
      status_mode_reg <= select_sync;
      power_strap_reg <= power_sync;
      debug_strap_reg <= debug_sync;
      addr_strap_reg <= gpio_sync[`MSSC_MGMT_ADDR_MSB:`MSSC_MGMT_ADDR_LSB];
    end
  end

  assign smbus_sync = pin_sync[0];

  // Register writes
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gpio_oe_reg <= `MSSC_RST_GPIO_OE;
      gpio_out_reg <= `MSSC_RST_GPIO_OUT;
      nvm_ctrl_reg <= `MSSC_RST_NVM_CTRL;
    end else if (i_clock_en && i_reg_wr) begin
      if (i_reg_addr == `MSSC_OFS_GPIO_OE) begin
        gpio_oe_reg <= i_reg_wdata[GPIO_W-1:0];
      end else if (i_reg_addr == `MSSC_OFS_GPIO_OUT) begin
        gpio_out_reg <= i_reg_wdata[GPIO_W-1:0];
      end else if (i_reg_addr == `MSSC_OFS_NVM_CTRL) begin
        nvm_ctrl_reg <= i_reg_wdata[`MSSC_NVM_DOE_BIT:`MSSC_NVM_CLK_BIT];
      end
    end
  end

  always_comb begin
    strap_word = 32'h0000_0000;
    strap_word[`MSSC_STRAP_NVM_EN_BIT] = nvm_enable_reg;
    strap_word[`MSSC_STRAP_SMBUS_BIT] = (proto_reg == MSSC_PROTO_SMBUS);
    strap_word[`MSSC_STRAP_STATUS_BIT] = status_mode_reg;
    strap_word[`MSSC_STRAP_PWR_BIT] = power_strap_reg;
    strap_word[`MSSC_STRAP_DBG_EN_BIT] = debug_strap_reg;
    strap_word[`MSSC_STRAP_ADDR_LSB +: 3] = addr_strap_reg;
    strap_word[`MSSC_STRAP_DBG_SEL_LSB +: 5] = o_debug_select;
    strap_word[`MSSC_STRAP_DONE_BIT] = (state_reg == MSSC_ST_RUN);
  end

  // Read decode, unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_reg_addr == `MSSC_OFS_GPIO_OE) begin
      rdata_next[GPIO_W-1:0] = gpio_oe_reg;
    end else if (i_reg_addr == `MSSC_OFS_GPIO_OUT) begin
      rdata_next[GPIO_W-1:0] = gpio_out_reg;
    end else if (i_reg_addr == `MSSC_OFS_GPIO_IN) begin
      rdata_next[GPIO_W-1:0] = gpio_sync;
    end else if (i_reg_addr == `MSSC_OFS_NVM_CTRL) begin
      rdata_next[`MSSC_NVM_DOE_BIT:`MSSC_NVM_CLK_BIT] = nvm_ctrl_reg;
      rdata_next[`MSSC_NVM_DIN_BIT] = nvm_data_sync;
    end else if (i_reg_addr == `MSSC_OFS_STRAP) begin
      rdata_next = strap_word;
    end else if (i_reg_addr == `MSSC_OFS_CLKREQ) begin
      rdata_next[PORTS-1:0] = clkreq_n_sync;
      rdata_next[2*PORTS-1:PORTS] = o_refclk_pll_enable;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_clock_en) begin
      o_reg_rdata <= i_reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // Memory serial pins, held idle and released while the strap is sampled or disabled
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_nvm_serial_clock <= 1'b0;
      o_nvm_serial_data <= 1'b0;
      o_nvm_serial_data_oe <= 1'b0;
    end else if (i_clock_en) begin
      o_nvm_serial_clock <= nvm_enable_reg & nvm_ctrl_reg[`MSSC_NVM_CLK_BIT];
      o_nvm_serial_data <= nvm_ctrl_reg[`MSSC_NVM_DOUT_BIT];
      o_nvm_serial_data_oe <= nvm_enable_reg & nvm_ctrl_reg[`MSSC_NVM_DOE_BIT];
    end
  end

  // Management bus, open-drain data, clock only sampled
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mgmt_bus_data <= 1'b0;
      o_mgmt_bus_data_oe <= 1'b0;
      o_mgmt_clock_in <= 1'b1;
      o_mgmt_data_in <= 1'b1;
      o_mgmt_address <= 3'h0;
      o_mgmt_smbus_mode <= 1'b0;
    end else if (i_clock_en) begin
      o_mgmt_bus_data <= 1'b0;
      o_mgmt_bus_data_oe <= i_mgmt_data_drive_low;
      o_mgmt_clock_in <= mgmt_clock_sync;
      o_mgmt_data_in <= mgmt_data_sync;
      o_mgmt_address <= (proto_reg == MSSC_PROTO_SMBUS) ? addr_strap_reg : 3'h0;
      o_mgmt_smbus_mode <= (proto_reg == MSSC_PROTO_SMBUS);
    end
  end

  // Scan control pin
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_scan_enable <= 1'b0;
      o_scan_enable_oe <= 1'b0;
      o_scan_enable_in <= 1'b0;
    end else if (i_clock_en) begin
      o_scan_enable <= 1'b0;
      o_scan_enable_oe <= ~test_sync;
      o_scan_enable_in <= test_sync & scan_sync;
    end
  end

  // General pins, outputs kept off until the straps are taken
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gpio <= `MSSC_RST_GPIO_OUT;
      o_gpio_oe <= `MSSC_RST_GPIO_OE;
    end else if (i_clock_en) begin
      o_gpio <= gpio_out_reg;
      o_gpio_oe <= (state_reg == MSSC_ST_RUN) ? gpio_oe_reg : `MSSC_RST_GPIO_OE;
    end
  end

  // Debug mode and power saving
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_debug_mode <= 1'b0;
      o_debug_select <= 5'h00;
      o_power_saving_enable <= 1'b0;
      o_strap_done <= 1'b0;
    end else if (i_clock_en) begin
      o_debug_mode <= ~debug_strap_reg;
      o_debug_select <= debug_strap_reg ? 5'h00 : gpio_sync[`MSSC_DBG_SEL_MSB:0];
      o_power_saving_enable <= power_strap_reg;
      o_strap_done <= (state_reg == MSSC_ST_RUN);
    end
  end

  // Per-port status or clock-request handling
  genvar g_port;
  generate
    for (g_port = 0; g_port < PORTS; g_port = g_port + 1) begin : g_port_ctl
      always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_port_status_out[g_port] <= 1'b0;
          o_refclk_pll_enable[g_port] <= 1'b1;
        end else if (i_clock_en) begin
          o_port_status_out[g_port] <= status_mode_reg & i_port_status[g_port];
          o_refclk_pll_enable[g_port] <= status_mode_reg | ~clkreq_n_sync[g_port];
        end
      end
    end
  endgenerate

endmodule

// ### tb/mssc_top_chk.sv
// Concurrent checks on the strap and sideband block ports
`timescale 1ns/1ps
module mssc_top_chk #(
  parameter int PORTS = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_mgmt_data_drive_low,
  input wire logic o_mgmt_bus_data,
  input wire logic o_mgmt_bus_data_oe,
  input wire logic i_manufacturing_test,
  input wire logic o_scan_enable,
  input wire logic o_scan_enable_oe,
  input wire logic o_strap_done,
  input wire logic o_power_saving_enable,
  input wire logic o_debug_mode,
  input wire logic [4:0] o_debug_select,
  input wire logic [PORTS-1:0] i_port_status,
  input wire logic [PORTS-1:0] o_port_status_out,
  input wire logic [PORTS-1:0] i_clock_request_n,
  input wire logic [PORTS-1:0] o_refclk_pll_enable
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_release;
    $rose(i_rst_b);
  endsequence
  sequence s_capture;
    !o_strap_done ##[3:7] o_strap_done;
  endsequence
  a_mgmt_open_drain: assert property (o_mgmt_bus_data_oe == $past(i_mgmt_data_drive_low) && !o_mgmt_bus_data)
    else $error("management data not open drain");
  a_scan_drive_low: assert property (!i_manufacturing_test [*4] |-> o_scan_enable_oe && !o_scan_enable)
    else $error("scan pin not driven low");
  a_scan_turn_input: assert property (i_manufacturing_test [*4] |-> !o_scan_enable_oe)
    else $error("scan pin still driven in test");
  a_strap_capture_time: assert property (s_release |-> s_capture)
    else $error("straps not captured in time");
  a_straps_held: assert property (o_strap_done |=> o_strap_done && $stable({o_power_saving_enable, o_debug_mode}))
    else $error("captured straps changed");
  a_debug_sel_gate: assert property (o_debug_select != 5'h00 |-> o_debug_mode)
    else $error("debug code outside debug mode");
  a_status_copy: assert property ((o_port_status_out & ~$past(i_port_status)) == '0)
    else $error("port status output not from port status");
  a_clkreq_follow: assert property ((~o_refclk_pll_enable & ~$past(i_clock_request_n, 3)) == '0)
    else $error("clock stopped while request asserted");
endmodule
bind mssc_top mssc_top_chk #(.PORTS(PORTS)) i_mssc_top_chk (.i_clock, .i_rst_b, .i_mgmt_data_drive_low,
  .o_mgmt_bus_data, .o_mgmt_bus_data_oe, .i_manufacturing_test, .o_scan_enable, .o_scan_enable_oe, .o_strap_done,
  .o_power_saving_enable, .o_debug_mode, .o_debug_select, .i_port_status, .o_port_status_out, .i_clock_request_n,
  .o_refclk_pll_enable);

// ### tb/mssc_partner.sv
// Board straps and serial memory model at the far side of the pins
`timescale 1ns/1ps
module mssc_partner (
  input wire logic i_nvm_out,
  input wire logic i_nvm_oe,
  input wire logic i_rom_drive,
  input wire logic i_rom_bit,
  input wire logic i_mgmt_out,
  input wire logic i_mgmt_oe,
  input wire logic i_debug_want,
  output logic o_nvm_pin,
  output logic o_mgmt_pin,
  output logic o_debug_strap
);
  // Released memory data line floats high on its pull-up
  assign o_nvm_pin = i_nvm_oe ? i_nvm_out : (i_rom_drive ? i_rom_bit : 1'b1);
  assign o_mgmt_pin = !(i_mgmt_oe && !i_mgmt_out);
  assign o_debug_strap = !i_debug_want;
endmodule

// ### tb/tb.sv
// Self-checking bench for the strap and sideband block
`timescale 1ns/1ps
`include "mssc_map.svh"
module tb;
  logic i_clock;
  logic i_rst_b = 0, i_reg_wr = 0, i_reg_rd = 0, i_manufacturing_test = 0, i_scan_enable = 0;
  logic i_mgmt_data_drive_low = 0, i_mgmt_bus_clock = 1, rom_drv = 0, rom_bit = 0, dbg = 0;
  logic i_power_saving_select = 0, i_status_or_substate_select = 0;
  logic clk_en = 1, i_mgmt_protocol_select = 0;
  logic [7:0] i_reg_addr = 0, i_gpio = 0, o_gpio, o_gpio_oe;
  logic [31:0] i_reg_wdata = 0, o_reg_rdata, got;
  logic [3:0] i_port_status = 0, i_clock_request_n = 4'hf, o_port_status_out, o_refclk_pll_enable;
  logic o_nvm_serial_clock, o_nvm_serial_data, o_nvm_serial_data_oe, o_mgmt_bus_data, o_mgmt_bus_data_oe;
  logic o_mgmt_clock_in, o_mgmt_data_in, o_mgmt_smbus_mode, o_scan_enable, o_scan_enable_oe, o_scan_enable_in;
  logic o_debug_mode, o_power_saving_enable, o_strap_done, i_nvm_serial_data, i_mgmt_bus_data, i_debug_enable_strap;
  logic [2:0] o_mgmt_address;
  logic [4:0] o_debug_select;
  int fail_count = 0, n_checks = 0;
  mssc_top i_mssc_top (.i_clock, .i_rst_b, .i_clock_en(clk_en), .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .i_mgmt_protocol_select,
    .o_reg_rdata, .o_nvm_serial_clock, .i_nvm_serial_data, .o_nvm_serial_data, .o_nvm_serial_data_oe,
    .i_mgmt_bus_clock, .i_mgmt_bus_data, .o_mgmt_bus_data, .o_mgmt_bus_data_oe, .i_mgmt_data_drive_low,
    .o_mgmt_clock_in, .o_mgmt_data_in, .o_mgmt_address, .o_mgmt_smbus_mode, .i_manufacturing_test, .i_scan_enable,
    .o_scan_enable, .o_scan_enable_oe, .o_scan_enable_in, .i_gpio, .o_gpio, .o_gpio_oe, .i_debug_enable_strap,
    .o_debug_mode, .o_debug_select, .i_power_saving_select, .o_power_saving_enable, .i_status_or_substate_select,
    .i_port_status, .o_port_status_out, .i_clock_request_n, .o_refclk_pll_enable, .o_strap_done);
  mssc_partner i_mssc_partner (.i_nvm_out(o_nvm_serial_data), .i_nvm_oe(o_nvm_serial_data_oe),
    .i_rom_drive(rom_drv), .i_rom_bit(rom_bit), .i_mgmt_out(o_mgmt_bus_data), .i_mgmt_oe(o_mgmt_bus_data_oe),
    .i_debug_want(dbg), .o_nvm_pin(i_nvm_serial_data), .o_mgmt_pin(i_mgmt_bus_data),
    .o_debug_strap(i_debug_enable_strap));
  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_reg_rd <= 1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 0;
    #1 got = o_reg_rdata;
  endtask
  // Strap levels: protocol select, memory pin held low, debug wanted, status select, power select
  task automatic boot(input logic [7:0] g, input logic [4:0] s);
    @(posedge i_clock);
    i_rst_b <= 0;
    i_gpio <= g;
    {i_mgmt_protocol_select, rom_drv, dbg, i_status_or_substate_select, i_power_saving_select} <= s;
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1;
    tick(8);
  endtask
  task automatic t_status;
    boot(8'ha0, 5'b10011);
    @(posedge i_clock);
    i_port_status <= 4'h9;
    i_power_saving_select <= 0;
    i_gpio <= 8'h1f;
    tick(4);
    rd(`MSSC_OFS_STRAP);
    chk("strap", 32'h8000_051f, got & 32'h801f_071f);
    chk("pwr", 1, o_power_saving_enable);
    chk("dbg", 0, o_debug_mode);
    chk("dsel", 0, o_debug_select);
    chk("pst", 4'h9, o_port_status_out);
    chk("refclk", 4'hf, o_refclk_pll_enable);
    chk("addr", 3'h5, o_mgmt_address);
    chk("smb", 1, o_mgmt_smbus_mode);
    $display("t_status done");
  endtask
  task automatic t_nvm;
    wr(`MSSC_OFS_NVM_CTRL, 32'h7);
    tick(1);
    chk("nvm", 3'h7, {o_nvm_serial_clock, o_nvm_serial_data, o_nvm_serial_data_oe});
    wr(`MSSC_OFS_NVM_CTRL, 32'h1);
    rom_drv <= 1;
    tick(5);
    rd(`MSSC_OFS_NVM_CTRL);
    chk("nvm_in0", 32'h1, got);
    rom_bit <= 1;
    tick(4);
    rd(`MSSC_OFS_NVM_CTRL);
    chk("nvm_in1", 32'h9, got);
    rom_drv <= 0;
    rom_bit <= 0;
    $display("t_nvm done");
  endtask
  task automatic t_gpio;
    wr(`MSSC_OFS_GPIO_OE, 32'hf0);
    wr(`MSSC_OFS_GPIO_OUT, 32'ha5);
    tick(1);
    chk("gpio", 16'hf0a5, {o_gpio_oe, o_gpio});
    rd(`MSSC_OFS_GPIO_OE);
    chk("goe_rd", 32'hf0, got);
    i_gpio <= 8'h3c;
    tick(4);
    wr(`MSSC_OFS_GPIO_IN, 32'hff);
    rd(`MSSC_OFS_GPIO_IN);
    chk("gpio_in", 32'h3c, got);
    tick(1);
    chk("rd_drop", 0, o_reg_rdata);
    rd(8'h40);
    chk("unmapped", 0, got);
    $display("t_gpio done");
  endtask
  task automatic t_freeze;
    @(posedge i_clock);
    clk_en <= 0;
    wr(`MSSC_OFS_GPIO_OUT, 32'h5a);
    rd(`MSSC_OFS_GPIO_OUT);
    chk("frz_rd", 0, got);
    chk("frz_gpio", 8'ha5, o_gpio);
    @(posedge i_clock);
    clk_en <= 1;
    tick(2);
    chk("frz_end", 8'ha5, o_gpio);
    $display("t_freeze done");
  endtask
  task automatic t_pins;
    @(posedge i_clock);
    i_mgmt_data_drive_low <= 1;
    i_mgmt_bus_clock <= 0;
    tick(6);
    chk("scan", 2'h2, {o_scan_enable_oe, o_scan_enable});
    chk("mgmt", 3'h4, {o_mgmt_bus_data_oe, o_mgmt_data_in, o_mgmt_clock_in});
    @(posedge i_clock);
    i_manufacturing_test <= 1;
    i_scan_enable <= 1;
    i_mgmt_data_drive_low <= 0;
    i_mgmt_bus_clock <= 1;
    tick(6);
    chk("scan_in", 2'h1, {o_scan_enable_oe, o_scan_enable_in});
    chk("mgmt_rel", 3'h3, {o_mgmt_bus_data_oe, o_mgmt_data_in, o_mgmt_clock_in});
    i_manufacturing_test <= 0;
    $display("t_pins done");
  endtask
  task automatic t_substate;
    boot(8'he3, 5'b01100);
    @(posedge i_clock);
    rom_drv <= 0;
    i_clock_request_n <= 4'h5;
    i_port_status <= 4'hf;
    tick(4);
    rd(`MSSC_OFS_STRAP);
    chk("strap", 32'h8003_0700, got & 32'h801f_071f);
    chk("pwr", 0, o_power_saving_enable);
    chk("addr0", 0, o_mgmt_address);
    chk("smb0", 0, o_mgmt_smbus_mode);
    chk("dbg", 1, o_debug_mode);
    chk("dsel", 5'h03, o_debug_select);
    chk("pst", 0, o_port_status_out);
    chk("refclk", 4'ha, o_refclk_pll_enable);
    wr(`MSSC_OFS_NVM_CTRL, 32'h7);
    tick(1);
    chk("nvm_off", 0, {o_nvm_serial_clock, o_nvm_serial_data_oe});
    $display("t_substate done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
  initial begin
    t_status();
    t_nvm();
    t_gpio();
    t_freeze();
    t_pins();
    t_substate();
    end_of_test();
  end
endmodule
